// ### hw/nxa_unit.sv
// Purpose: accumulator datapath for register swap and add-with-carry
// Assumes: sequencer holds INSTR with INSTR_VALID high for one cycle per op
// Notes:   two-cycle op: register read, then commit; INSTR_READY low while busy
//          accumulator load port is heard only while idle
//
// Behaviour
// [RL1] Upper nibble 1011 decodes as swap; lower nibble selects the register.
// [RL2] Swap moves register into accumulator and accumulator into register together.
// [RL3] Upper nibble 1000 decodes as add-with-carry; lower nibble selects operand.
// [RL4] Add sums register, accumulator and carry; low four bits go to accumulator.
// [RL5] Carry becomes 1 when the sum exceeds fifteen, else 0.
// [RL6] Add leaves the operand register untouched; only accumulator and carry change.
// [RL7] Select field addresses one of sixteen registers by its plain binary value.
module nxa_unit
   import nxa_pkg::*;
(
   input  wire logic       MCLK,
   input  wire logic       RST_N,
   input  wire logic [7:0] INSTR,
   input  wire logic       INSTR_VALID,
   input  wire logic       ACC_LOAD,
   input  wire logic [3:0] ACC_LOAD_DATA,
   input  wire logic       LINK_LOAD_DATA,
   output logic            INSTR_READY,
   output logic [3:0]      ACC,
   output logic            CARRY_LINK_BIT,
   output logic            DONE
);
   typedef enum logic [1:0] {NXA_IDLE, NXA_EXEC} nxa_state_t;

   typedef struct packed {
      nxa_state_t st;
      logic [3:0] op;
      logic [3:0] sel;
      logic [3:0] acc;
      logic       link;
      logic       done;
      logic       ready;
   } nxa_regs_t;

   nxa_regs_t r;
   nxa_regs_t next_r;

   logic [3:0] rf_rdata;
   logic       rf_we;
   logic [3:0] rf_wdata;

   function automatic logic [4:0] nxa_addc(input logic [3:0] a, input logic [3:0] b,
                                           input logic c);
      nxa_addc = {1'b0, a} + {1'b0, b} + {4'h0, c};
   endfunction : nxa_addc

   function automatic logic nxa_known(input logic [3:0] op);
      nxa_known = (op == NXA_OP_SWAP) || (op == NXA_OP_ADDC);
   endfunction : nxa_known

   // select field goes straight to the address, no remapping
   nxa_regfile #(
      .W (NXA_DATA_W),
      .N (NXA_REG_N)
   ) u_rf (
      .clk   (MCLK),
      .rst_n (RST_N),
      .we    (rf_we),
      .waddr (r.sel),      // RL7
      .wdata (rf_wdata),
      .raddr (INSTR[3:0]), // RL7
      .rdata (rf_rdata)
   );

   always_comb
   begin
      logic [4:0] sum;
      // adder runs every cycle; only the add commit uses it
      sum      = nxa_addc(rf_rdata, r.acc, r.link); // RL4
      next_r   = r;
      next_r.done = 1'b0;
      rf_we    = 1'b0;
      rf_wdata = r.acc;
      case (r.st)
         NXA_IDLE:
         begin
            // other instructions write the accumulator through this port; it is
            // only heard between ops so a commit can never be overrun
            if (ACC_LOAD)
            begin
               next_r.acc  = ACC_LOAD_DATA;
               next_r.link = LINK_LOAD_DATA;
            end
            // unknown opcodes are ignored; other units own them
            if (INSTR_VALID && nxa_known(INSTR[7:4]))
            begin
               next_r.op    = INSTR[7:4];
               next_r.sel   = INSTR[3:0];
               next_r.st    = NXA_EXEC;
               next_r.ready = 1'b0;
            end
         end
         NXA_EXEC:
         begin
            if (r.op == NXA_OP_SWAP) // RL1
            begin
               // old accumulator written while register value is latched: one edge
               rf_we      = 1'b1;       // RL2
               next_r.acc = rf_rdata;   // RL2
            end
            else if (r.op == NXA_OP_ADDC) // RL3
            begin
               next_r.acc  = sum[3:0]; // RL4
               next_r.link = sum[4];   // RL5
               rf_we       = 1'b0;     // RL6
            end
            next_r.done  = 1'b1;
            next_r.ready = 1'b1;
            next_r.st    = NXA_IDLE;
         end
         default:
         begin
            next_r.st    = NXA_IDLE;
            next_r.ready = 1'b1;
         end
      endcase
   end

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         r.st    <= NXA_IDLE;
         r.op    <= 4'h0;
         r.sel   <= 4'h0;
         r.acc   <= NXA_ACC_RST;
         r.link  <= NXA_LINK_RST;
         r.done  <= 1'b0;
         r.ready <= 1'b1;
      end
      else
      begin
         r <= next_r;
      end
   end

   // every output is a register field, no logic after the flops
   assign INSTR_READY    = r.ready;
   assign ACC            = r.acc;
   assign CARRY_LINK_BIT = r.link;
   assign DONE           = r.done;

   // sizes are fixed by the nibble-wide ports; refuse a package that disagrees
   if (NXA_DATA_W != $bits(ACC) || NXA_REG_N != 2 ** NXA_DATA_W)
   begin : g_bad_cfg
      $error("nxa_unit: package sizes do not fit the ports");
   end

   // handshake: one busy cycle, then a single done pulse
   AST_BUSY_ONE: assert property (@(posedge MCLK) disable iff (!RST_N)
      !INSTR_READY |=> INSTR_READY && DONE)
      else $error("busy did not end in one cycle with done");
   AST_DONE_PULSE: assert property (@(posedge MCLK) disable iff (!RST_N)
      DONE |=> !DONE)
      else $error("done stood longer than one cycle");
   AST_UNKNOWN_IGNORED: assert property (@(posedge MCLK) disable iff (!RST_N) // RL1
      (r.st == NXA_IDLE && INSTR_VALID && !nxa_known(INSTR[7:4])) |=> INSTR_READY)
      else $error("foreign opcode was taken");

   // the register file is written by swaps only
   AST_RF_WRITE_SWAP: assert property (@(posedge MCLK) disable iff (!RST_N) // RL6
      rf_we |-> r.st == NXA_EXEC && r.op == NXA_OP_SWAP)
      else $error("register written outside a swap");
   // loads stand in for the other accumulator-writing instructions
   AST_LOAD_IDLE: assert property (@(posedge MCLK) disable iff (!RST_N)
      (r.st == NXA_IDLE && ACC_LOAD)
      |=> ACC == $past(ACC_LOAD_DATA) && CARRY_LINK_BIT == $past(LINK_LOAD_DATA))
      else $error("accumulator load lost");
   AST_ACC_HOLD: assert property (@(posedge MCLK) disable iff (!RST_N)
      (r.st == NXA_IDLE && !ACC_LOAD) |=> $stable(ACC) && $stable(CARRY_LINK_BIT))
      else $error("accumulator changed with no op");

   AST_SWAP_ACC: assert property (@(posedge MCLK) disable iff (!RST_N)  // RL2
      (r.st == NXA_EXEC && r.op == NXA_OP_SWAP) |=> ACC == $past(rf_rdata))
      else $error("swap did not load register into accumulator");
   AST_SWAP_REG: assert property (@(posedge MCLK) disable iff (!RST_N)  // RL2
      (r.st == NXA_EXEC && r.op == NXA_OP_SWAP) |-> rf_we && rf_wdata == r.acc)
      else $error("swap did not store accumulator into register");
   AST_SWAP_LINK: assert property (@(posedge MCLK) disable iff (!RST_N) // RL2
      (r.st == NXA_EXEC && r.op == NXA_OP_SWAP) |=> $stable(CARRY_LINK_BIT))
      else $error("swap changed carry");
   AST_DECODE_SWAP: assert property (@(posedge MCLK) disable iff (!RST_N) // RL1
      (r.st == NXA_IDLE && INSTR_VALID && INSTR[7:4] == 4'hB)
      |=> r.st == NXA_EXEC && r.op == NXA_OP_SWAP && r.sel == $past(INSTR[3:0]))
      else $error("swap opcode not decoded");
   AST_DECODE_ADD: assert property (@(posedge MCLK) disable iff (!RST_N) // RL3
      (r.st == NXA_IDLE && INSTR_VALID && INSTR[7:4] == 4'h8)
      |=> r.st == NXA_EXEC && r.op == NXA_OP_ADDC ##1 DONE)
      else $error("add opcode not decoded");
   AST_ADD_SUM: assert property (@(posedge MCLK) disable iff (!RST_N) // RL4
      (r.st == NXA_EXEC && r.op == NXA_OP_ADDC)
      |=> ACC == 4'(($past(rf_rdata) + $past(r.acc) + $past(r.link)) & 5'h0F))
      else $error("add result wrong");
   AST_ADD_CARRY: assert property (@(posedge MCLK) disable iff (!RST_N) // RL5
      (r.st == NXA_EXEC && r.op == NXA_OP_ADDC)
      |=> CARRY_LINK_BIT == (5'($past(rf_rdata)) + 5'($past(r.acc))
                             + 5'($past(r.link)) > 5'h0F))
      else $error("add carry wrong");
   AST_ADD_NOWRITE: assert property (@(posedge MCLK) disable iff (!RST_N) // RL6
      (r.st == NXA_EXEC && r.op == NXA_OP_ADDC) |-> !rf_we)
      else $error("add wrote the operand register");
   AST_SEL_DIRECT: assert property (@(posedge MCLK) disable iff (!RST_N) // RL7
      (r.st == NXA_EXEC && r.op == NXA_OP_SWAP) ##1 (r.st == NXA_IDLE && INSTR_VALID
      && INSTR[7:0] == {NXA_OP_SWAP, $past(r.sel)}) ##1 1'b1
      |=> ACC == $past(ACC, 3))
      else $error("select did not address the same register");

   // main scenarios: both ops, both carry outcomes, back-to-back, repeated swap
   COV_SWAP: cover property (@(posedge MCLK) disable iff (!RST_N)
      r.st == NXA_EXEC && r.op == NXA_OP_SWAP);
   COV_ADD_CARRY: cover property (@(posedge MCLK) disable iff (!RST_N)
      r.st == NXA_EXEC && r.op == NXA_OP_ADDC ##1 CARRY_LINK_BIT);
   COV_ADD_NOCARRY: cover property (@(posedge MCLK) disable iff (!RST_N)
      r.st == NXA_EXEC && r.op == NXA_OP_ADDC && r.link ##1 !CARRY_LINK_BIT);
   COV_BACK2BACK: cover property (@(posedge MCLK) disable iff (!RST_N)
      DONE && INSTR_VALID && nxa_known(INSTR[7:4]));
   COV_SAME_SWAP: cover property (@(posedge MCLK) disable iff (!RST_N)
      DONE && r.op == NXA_OP_SWAP && INSTR_VALID && INSTR[7:0] == {NXA_OP_SWAP, r.sel});
endmodule : nxa_unit

// ### hw/nxa_pkg.sv
// Purpose: shared constants for the nibble exchange/add datapath
// Assumes: 8-bit instruction word, upper nibble opcode, lower nibble select
// Notes:   constants only
package nxa_pkg;
   localparam int          NXA_DATA_W   = 4;
   localparam int          NXA_REG_N    = 16;
   localparam logic [3:0]  NXA_OP_SWAP  = 4'hB;
   localparam logic [3:0]  NXA_OP_ADDC  = 4'h8;
   localparam logic [3:0]  NXA_ACC_RST  = 4'h0;
   localparam logic        NXA_LINK_RST = 1'b0;
   localparam logic [3:0]  NXA_REG_RST  = 4'h0;
endpackage : nxa_pkg

// ### hw/nxa_regfile.sv
// Purpose: sixteen-entry index register file, one write port, one read port
// Assumes: registered read data, write and read addressed by plain binary index
// Notes:   read of a location written in the same cycle returns the old value
module nxa_regfile
   import nxa_pkg::*;
#(
   parameter int W = NXA_DATA_W,
   parameter int N = NXA_REG_N
)
(
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 we,
   input  wire logic [$clog2(N)-1:0] waddr,
   input  wire logic [W-1:0]         wdata,
   input  wire logic [$clog2(N)-1:0] raddr,
   output logic      [W-1:0]         rdata
);
   logic [W-1:0] mem [N];

   // plain binary addressing needs a power-of-two depth
   if (N < 2 || W < 1 || N != (1 << $clog2(N)))
   begin : g_bad_size
      $error("nxa_regfile: bad size");
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < N; i++) mem[i] <= W'(NXA_REG_RST);
         rdata <= W'(NXA_REG_RST);
      end
      else
      begin
         rdata <= mem[raddr];
         if (we) mem[waddr] <= wdata;
      end
   end
endmodule : nxa_regfile

// ### tb/nxa_seq_model.sv
// Purpose: sequencer stand-in that presents instruction words to the unit
// Assumes: caller acts 1 ns after a rising MCLK edge
// Notes:   idle word is inverted so a stale opcode never looks fresh
module nxa_seq_model
(
   input  wire logic       clk,
   input  wire logic       ready,
   output logic      [7:0] instr,
   output logic            valid,
   output logic            acc_load,
   output logic      [3:0] acc_load_data,
   output logic            link_load_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      instr = 8'h00;
      valid = 1'b0;
      acc_load = 1'b0;
      acc_load_data = 4'h0;
      link_load_data = 1'b0;
   end
   // one-cycle accumulator load; caller must be between ops
   task automatic load(input logic [3:0] a, input logic c);
      acc_load = 1'b1;
      acc_load_data = a;
      link_load_data = c;
      @(posedge clk) #1;
      acc_load = 1'b0;
   endtask : load
   // holds word and valid until the edge that takes it
   task automatic send(input logic [7:0] w);
      int n = 0;
      instr = w;
      valid = 1'b1;
      while (ready !== 1'b1 && n < 20)
      begin
         @(posedge clk) #1;
         n++;
      end
      @(posedge clk) #1;
   endtask : send
   task automatic idle();
      valid = 1'b0;
      instr = ~instr;
   endtask : idle
endmodule : nxa_seq_model

// ### tb/nxa_unit_test.sv
// Purpose: self-checking bench for the swap / add-with-carry datapath
// Assumes: registers clear on reset; the load port seeds accumulator and carry
// Notes:   swaps carry seeded values into and back out of the index registers
module nxa_unit_test
   import nxa_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       MCLK, RST_N, INSTR_VALID, INSTR_READY, CARRY_LINK_BIT, DONE;
   logic [7:0] INSTR;
   logic       ACC_LOAD, LINK_LOAD_DATA;
   logic [3:0] ACC_LOAD_DATA;
   logic [3:0] ACC, m_acc;
   logic [3:0] m_reg [16];
   logic       m_c;
   int         failures = 0;
   int         total_checks = 0;
   nxa_unit dut (.MCLK(MCLK), .RST_N(RST_N), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
      .ACC_LOAD(ACC_LOAD), .ACC_LOAD_DATA(ACC_LOAD_DATA), .LINK_LOAD_DATA(LINK_LOAD_DATA),
      .INSTR_READY(INSTR_READY), .ACC(ACC), .CARRY_LINK_BIT(CARRY_LINK_BIT), .DONE(DONE));
   nxa_seq_model seq (.clk(MCLK), .ready(INSTR_READY), .instr(INSTR), .valid(INSTR_VALID),
      .acc_load(ACC_LOAD), .acc_load_data(ACC_LOAD_DATA), .link_load_data(LINK_LOAD_DATA));
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic summarize();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   task automatic t_reset();
      @(posedge MCLK) #1 RST_N = 1'b0;
      repeat (2) @(posedge MCLK);
      #1 RST_N = 1'b1;
      m_acc = NXA_ACC_RST;
      m_c = NXA_LINK_RST;
      foreach (m_reg[i]) m_reg[i] = NXA_REG_RST;
      check("reset acc", 8'h00, {4'h0, ACC});
      check("reset carry", 8'h00, {7'h0, CARRY_LINK_BIT});
      check("reset ready", 8'h01, {7'h0, INSTR_READY});
      check("reset done", 8'h00, {7'h0, DONE});
   endtask : t_reset
   // one op, expectation from the reference model, DONE exactly two edges on
   task automatic run_op(input logic [7:0] w);
      logic [4:0] sum;
      seq.send(w);
      seq.idle();
      check("busy ready", 8'h00, {7'h0, INSTR_READY});
      check("early done", 8'h00, {7'h0, DONE});
      sum = m_reg[w[3:0]] + m_acc + m_c;
      if (w[7:4] === NXA_OP_SWAP)
         {m_acc, m_reg[w[3:0]]} = {m_reg[w[3:0]], m_acc};
      else
         {m_c, m_acc} = sum;
      @(posedge MCLK) #1;
      check("done", 8'h01, {7'h0, DONE});
      check("acc", {4'h0, m_acc}, {4'h0, ACC});
      check("carry", {7'h0, m_c}, {7'h0, CARRY_LINK_BIT});
      check("ready back", 8'h01, {7'h0, INSTR_READY});
   endtask : run_op
   // seeds accumulator and carry through the load port, between ops only
   task automatic t_load(input logic [3:0] a, input logic c);
      seq.load(a, c);
      m_acc = a;
      m_c = c;
      check("load acc", {4'h0, m_acc}, {4'h0, ACC});
      check("load carry", {7'h0, m_c}, {7'h0, CARRY_LINK_BIT});
   endtask : t_load
   // swaps seed every register, adds hit both carry outcomes, swaps read back
   task automatic t_selects();
      for (int s = 0; s < 16; s++)
      begin
         t_load(s[3:0] ^ 4'h9, s[0]);
         run_op({NXA_OP_SWAP, s[3:0]});
      end
      for (int s = 0; s < 16; s++)
      begin
         t_load(4'hF - s[3:0], s[1]);
         run_op({NXA_OP_ADDC, s[3:0]});
      end
      for (int s = 0; s < 16; s++) run_op({NXA_OP_SWAP, s[3:0]});
      // same register twice: the second swap undoes the first
      run_op({NXA_OP_SWAP, 4'h3});
      run_op({NXA_OP_SWAP, 4'h3});
   endtask : t_selects
   // foreign opcodes must draw no answer at all
   task automatic t_unknown();
      logic [3:0] ops [4] = '{4'h0, 4'h9, 4'hA, 4'hF};
      foreach (ops[k])
      begin
         seq.send({ops[k], 4'h5});
         seq.idle();
         repeat (3)
         begin
            check("no done", 8'h00, {7'h0, DONE});
            check("still ready", 8'h01, {7'h0, INSTR_READY});
            @(posedge MCLK) #1;
         end
         check("acc kept", {4'h0, m_acc}, {4'h0, ACC});
         check("carry kept", {7'h0, m_c}, {7'h0, CARRY_LINK_BIT});
      end
   endtask : t_unknown
   initial
   begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end
   initial
   begin
      #20000;
      failures++;
      summarize();
   end
   initial
   begin
      RST_N = 1'b0;
      t_reset();
      t_selects();
      t_unknown();
      t_reset();
      t_selects();
      summarize();
   end
endmodule : nxa_unit_test
